// ### design/sfs_defs.vh
// Constants for the serial controller FIFO status and interrupt block.
// Assumes byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

// Register byte offsets
`define SFS_OFF_ENABLE      8'h08
`define SFS_OFF_TX_THR      8'h14
`define SFS_OFF_RX_THR      8'h18
`define SFS_OFF_TX_LVL      8'h1c
`define SFS_OFF_RX_LVL      8'h20
`define SFS_OFF_STATUS      8'h24
`define SFS_OFF_POLARITY    8'h28
`define SFS_OFF_MASK        8'h2c
`define SFS_OFF_MASKED      8'h30
`define SFS_OFF_RAW         8'h34
`define SFS_OFF_CLEAR       8'h38

// Field widths
`define SFS_THR_W           5
`define SFS_CNT_W           6
`define SFS_SRC_W           5

// FIFO depth in entries
`define SFS_DEPTH           6'h20

// Status bit positions
`define SFS_ST_RX_FULL      4
`define SFS_ST_RX_EMPTY     3
`define SFS_ST_TX_EMPTY     2
`define SFS_ST_TX_FULL      1
`define SFS_ST_ACTIVE       0

// Interrupt source positions
`define SFS_IRQ_RX_FULL     4
`define SFS_IRQ_RX_OVF      3
`define SFS_IRQ_RX_UNF      2
`define SFS_IRQ_TX_OVF      1
`define SFS_IRQ_TX_EMPTY    0

// Clear register bits
`define SFS_CLR_TX_OVF      3
`define SFS_CLR_RX_OVF      2
`define SFS_CLR_RX_UNF      1
`define SFS_CLR_ALL         0

// Reset values
`define SFS_RST_THR         5'h00
`define SFS_RST_CNT         6'h00
`define SFS_RST_MASK        5'h00
`define SFS_RST_POLARITY    1'h0
`define SFS_RST_ENABLE      1'h0

// Bus responses
`define SFS_RESP_OKAY       2'h0
`define SFS_RESP_SLVERR     2'h2

`endif

// ### design/sfs_fifo_status.v
// FIFO level, threshold, status and interrupt logic of a serial controller.
// Assumes the shift engine and data path report FIFO pushes, pops and busy
// synchronously on aclk; software reaches the registers over AXI4-Lite.
//
// Overview of operation
// - Transmit-empty source is high while transmit count is at or below threshold.
// - Receive-full source is high while receive count reaches threshold plus one.
// - Read-only 6-bit transmit level field, reset to zero.
// - Read-only 6-bit receive level field, reset to zero.
// - Status bit 4 shows receive FIFO full, reset to zero.
// - Status bit 3 shows receive FIFO empty.
// - Status bit 2 shows transmit FIFO empty, one after reset.
// - Status bit 1 shows transmit FIFO full, reset to zero.
// - Status bit 0 shows transfer in progress, low when idle or disabled.
// - Polarity bit zero gives active-high interrupt, one gives active-low.
// - One mask bit per source; one passes the source, zero blocks it.
// - All mask bits reset to zero.
// - Masked status is raw source gated by mask; both views readable.
// - Disabling the controller empties both FIFOs, levels read zero.
//
// Local design decision: the AXI4-Lite interface to the registers.

`timescale 1ns/1ps
`include "sfs_defs.vh"

module sfs_fifo_status (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // FIFO activity from the data path and shift engine
  input  wire        tx_push,
  input  wire        tx_pop,
  input  wire        rx_push,
  input  wire        rx_pop,
  input  wire        engine_busy,
  // Towards the shift engine
  output reg         controller_enable,
  output reg         tx_full_out,
  output reg         rx_empty_out,
  // Interrupt
  output reg         irq
);

  // Registers
  reg                    enable_q;
  reg [`SFS_THR_W-1:0]   tx_threshold_field_q;
  reg [`SFS_THR_W-1:0]   rx_threshold_field_q;
  reg [`SFS_CNT_W-1:0]   tx_count_field_q;
  reg [`SFS_CNT_W-1:0]   rx_count_field_q;
  reg                    irq_level_select_q;
  reg [`SFS_SRC_W-1:0]   irq_mask_q;
  reg [`SFS_SRC_W-1:0]   sticky_q;
  reg                    rx_full_flag_q;
  reg                    rx_empty_flag_q;
  reg                    tx_empty_flag_q;
  reg                    tx_full_flag_q;
  reg                    transfer_active_flag_q;

  // Bus state
  reg                    aw_held_q;
  reg                    w_held_q;
  reg [7:0]              waddr_q;
  reg [31:0]             wdata_q;
  reg [3:0]              wstrb_q;

  // Bus combinational
  wire                   aw_hs;
  wire                   w_hs;
  wire                   ar_hs;
  wire                   do_write;
  wire                   wr_lane0;
  wire                   aw_held_d;
  wire                   w_held_d;
  wire                   bvalid_d;
  wire                   rvalid_d;
  reg                    wr_mapped;
  reg                    rd_mapped;
  reg [31:0]             rd_value;

  // Write register selects
  reg                    sel_enable;
  reg                    sel_tx_thr;
  reg                    sel_rx_thr;
  reg                    sel_polarity;
  reg                    sel_mask;
  reg                    sel_clear;

  // Datapath combinational
  wire                   enable_d;
  wire                   tx_push_ok;
  wire                   tx_pop_ok;
  wire                   rx_push_ok;
  wire                   rx_pop_ok;
  wire [`SFS_CNT_W-1:0]  tx_count_d;
  wire [`SFS_CNT_W-1:0]  rx_count_d;
  wire [`SFS_SRC_W-1:0]  event_set;
  wire [`SFS_SRC_W-1:0]  event_clr;
  wire [`SFS_SRC_W-1:0]  sticky_d;
  wire [`SFS_SRC_W-1:0]  raw_status;
  wire [`SFS_SRC_W-1:0]  masked_status;
  wire [4:0]             status_word;
  wire                   raw_read;
  wire                   clr_write;

  // Write strobes and next-state flags
  wire                   wr_enable;
  wire                   wr_tx_thr;
  wire                   wr_rx_thr;
  wire                   wr_polarity;
  wire                   wr_mask;
  wire                   tx_full_d;
  wire                   tx_empty_d;
  wire                   rx_full_d;
  wire                   rx_empty_d;
  wire                   irq_d;

  // Handshakes
  assign aw_hs    = s_axi_awvalid & s_axi_awready;
  assign w_hs     = s_axi_wvalid & s_axi_wready;
  assign ar_hs    = s_axi_arvalid & s_axi_arready;
  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_lane0 = do_write & wstrb_q[0];

  assign aw_held_d = (aw_held_q & ~do_write) | aw_hs;
  assign w_held_d  = (w_held_q & ~do_write) | w_hs;
  assign bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_d  = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  // Write address decode; read-only offsets take the write and ignore it
  always @* begin
    wr_mapped    = 1'b1;
    sel_enable   = 1'b0;
    sel_tx_thr   = 1'b0;
    sel_rx_thr   = 1'b0;
    sel_polarity = 1'b0;
    sel_mask     = 1'b0;
    sel_clear    = 1'b0;
    case (waddr_q)
      `SFS_OFF_ENABLE:   sel_enable   = 1'b1;
      `SFS_OFF_TX_THR:   sel_tx_thr   = 1'b1;
      `SFS_OFF_RX_THR:   sel_rx_thr   = 1'b1;
      `SFS_OFF_POLARITY: sel_polarity = 1'b1;
      `SFS_OFF_MASK:     sel_mask     = 1'b1;
      `SFS_OFF_CLEAR:    sel_clear    = 1'b1;
      `SFS_OFF_TX_LVL,
      `SFS_OFF_RX_LVL,
      `SFS_OFF_STATUS,
      `SFS_OFF_MASKED,
      `SFS_OFF_RAW:      wr_mapped    = 1'b1;
      default:           wr_mapped    = 1'b0;
    endcase
  end

  // Per-register write strobes; only byte lane 0 carries fields
  assign wr_enable   = wr_lane0 & sel_enable;
  assign wr_tx_thr   = wr_lane0 & sel_tx_thr;
  assign wr_rx_thr   = wr_lane0 & sel_rx_thr;
  assign wr_polarity = wr_lane0 & sel_polarity;
  assign wr_mask     = wr_lane0 & sel_mask;

  // Enable and FIFO levels
  assign enable_d = wr_enable ? wdata_q[0] : enable_q;

  assign tx_push_ok = tx_push & ~tx_full_flag_q;
  assign tx_pop_ok  = tx_pop & ~tx_empty_flag_q;
  assign rx_push_ok = rx_push & ~rx_full_flag_q;
  assign rx_pop_ok  = rx_pop & ~rx_empty_flag_q;

  // Disabled controller holds both FIFOs empty
  assign tx_count_d = ~enable_d ? `SFS_RST_CNT :
                      tx_count_field_q + {5'h00, tx_push_ok} - {5'h00, tx_pop_ok};
  assign rx_count_d = ~enable_d ? `SFS_RST_CNT :
                      rx_count_field_q + {5'h00, rx_push_ok} - {5'h00, rx_pop_ok};

  // Next-state flags shared by status bits and engine outputs
  assign tx_full_d  = (tx_count_d == `SFS_DEPTH);
  assign tx_empty_d = (tx_count_d == `SFS_RST_CNT);
  assign rx_full_d  = (rx_count_d == `SFS_DEPTH);
  assign rx_empty_d = (rx_count_d == `SFS_RST_CNT);

  // Sticky events; threshold positions stay zero here
  // Next enable gates them, so a disabling write latches nothing
  assign event_set[`SFS_IRQ_RX_FULL]  = 1'b0;
  assign event_set[`SFS_IRQ_RX_OVF]   = enable_d & rx_push & rx_full_flag_q;
  assign event_set[`SFS_IRQ_RX_UNF]   = enable_d & rx_pop & rx_empty_flag_q;
  assign event_set[`SFS_IRQ_TX_OVF]   = enable_d & tx_push & tx_full_flag_q;
  assign event_set[`SFS_IRQ_TX_EMPTY] = 1'b0;

  assign raw_read  = ar_hs && s_axi_araddr == `SFS_OFF_RAW;
  assign clr_write = wr_lane0 & sel_clear;

  assign event_clr[`SFS_IRQ_RX_FULL]  = 1'b0;
  assign event_clr[`SFS_IRQ_RX_OVF]   = raw_read |
    (clr_write & (wdata_q[`SFS_CLR_RX_OVF] | wdata_q[`SFS_CLR_ALL]));
  assign event_clr[`SFS_IRQ_RX_UNF]   = raw_read |
    (clr_write & (wdata_q[`SFS_CLR_RX_UNF] | wdata_q[`SFS_CLR_ALL]));
  assign event_clr[`SFS_IRQ_TX_OVF]   = raw_read |
    (clr_write & (wdata_q[`SFS_CLR_TX_OVF] | wdata_q[`SFS_CLR_ALL]));
  assign event_clr[`SFS_IRQ_TX_EMPTY] = 1'b0;

  // A new event beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `SFS_SRC_W; gi = gi + 1) begin : g_sticky
      assign sticky_d[gi] = event_set[gi] | (sticky_q[gi] & ~event_clr[gi]);
    end
  endgenerate

  // Raw and masked views
  assign raw_status[`SFS_IRQ_RX_FULL]  =
    (rx_count_field_q >= ({1'b0, rx_threshold_field_q} + 6'h01));
  assign raw_status[`SFS_IRQ_RX_OVF]   = sticky_q[`SFS_IRQ_RX_OVF];
  assign raw_status[`SFS_IRQ_RX_UNF]   = sticky_q[`SFS_IRQ_RX_UNF];
  assign raw_status[`SFS_IRQ_TX_OVF]   = sticky_q[`SFS_IRQ_TX_OVF];
  assign raw_status[`SFS_IRQ_TX_EMPTY] =
    (tx_count_field_q <= {1'b0, tx_threshold_field_q});
  assign masked_status = raw_status & irq_mask_q;
  // Polarity one inverts the line, so it idles high when active-low
  assign irq_d = (|masked_status) ^ irq_level_select_q;

  assign status_word = {rx_full_flag_q, rx_empty_flag_q, tx_empty_flag_q,
                        tx_full_flag_q, transfer_active_flag_q};

  // Read mux; unmapped reads return zero with an error
  always @* begin
    rd_mapped = 1'b1;
    rd_value  = 32'h0000_0000;
    case (s_axi_araddr)
      `SFS_OFF_ENABLE:   rd_value = {31'h0000_0000, enable_q};
      `SFS_OFF_TX_THR:   rd_value = {27'h000_0000, tx_threshold_field_q};
      `SFS_OFF_RX_THR:   rd_value = {27'h000_0000, rx_threshold_field_q};
      `SFS_OFF_TX_LVL:   rd_value = {26'h000_0000, tx_count_field_q};
      `SFS_OFF_RX_LVL:   rd_value = {26'h000_0000, rx_count_field_q};
      `SFS_OFF_STATUS:   rd_value = {27'h000_0000, status_word};
      `SFS_OFF_POLARITY: rd_value = {31'h0000_0000, irq_level_select_q};
      `SFS_OFF_MASK:     rd_value = {27'h000_0000, irq_mask_q};
      `SFS_OFF_MASKED:   rd_value = {27'h000_0000, masked_status};
      `SFS_OFF_RAW:      rd_value = {27'h000_0000, raw_status};
      `SFS_OFF_CLEAR:    rd_value = 32'h0000_0000;
      default:           rd_mapped = 1'b0;
    endcase
  end

  // Bus channel registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      waddr_q       <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SFS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SFS_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      // One write in flight; ready drops until the response is taken
      s_axi_awready <= ~aw_held_d & ~bvalid_d;
      s_axi_wready  <= ~w_held_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (aw_hs) begin
        waddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
      end
      if (ar_hs) begin
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_mapped ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
      end
    end
  end

  // Control registers; only byte lane 0 carries fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_q             <= `SFS_RST_ENABLE;
      tx_threshold_field_q <= `SFS_RST_THR;
      rx_threshold_field_q <= `SFS_RST_THR;
      irq_level_select_q   <= `SFS_RST_POLARITY;
      irq_mask_q           <= `SFS_RST_MASK;
    end else begin
      enable_q <= enable_d;
      if (wr_tx_thr) begin
        tx_threshold_field_q <= wdata_q[`SFS_THR_W-1:0];
      end
      if (wr_rx_thr) begin
        rx_threshold_field_q <= wdata_q[`SFS_THR_W-1:0];
      end
      if (wr_polarity) begin
        irq_level_select_q <= wdata_q[0];
      end
      if (wr_mask) begin
        irq_mask_q <= wdata_q[`SFS_SRC_W-1:0];
      end
    end
  end

  // Levels, flags and sticky events
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_count_field_q       <= `SFS_RST_CNT;
      rx_count_field_q       <= `SFS_RST_CNT;
      sticky_q               <= 5'h00;
      rx_full_flag_q         <= 1'b0;
      rx_empty_flag_q        <= 1'b1;
      tx_empty_flag_q        <= 1'b1;
      tx_full_flag_q         <= 1'b0;
      transfer_active_flag_q <= 1'b0;
    end else begin
      tx_count_field_q       <= tx_count_d;
      rx_count_field_q       <= rx_count_d;
      sticky_q               <= sticky_d;
      // Flags follow the new count so they never lag the level field
      rx_full_flag_q         <= rx_full_d;
      rx_empty_flag_q        <= rx_empty_d;
      tx_empty_flag_q        <= tx_empty_d;
      tx_full_flag_q         <= tx_full_d;
      transfer_active_flag_q <= enable_d & engine_busy;
    end
  end

  // Outputs to engine and interrupt line
  always @(posedge aclk) begin
    if (!aresetn) begin
      controller_enable <= 1'b0;
      tx_full_out       <= 1'b0;
      rx_empty_out      <= 1'b1;
      irq               <= 1'b0;
    end else begin
      controller_enable <= enable_d;
      tx_full_out       <= tx_full_d;
      rx_empty_out      <= rx_empty_d;
      // One cycle behind the status views, a trade for a clean output flop
      irq               <= irq_d;
    end
  end

endmodule // sfs_fifo_status

// ### sim/sfs_checker.sv
// Port checker for the FIFO status block, bound to its top module.
// Assumes strobes count only while enabled, depth 32 entries.
`timescale 1ns/1ps
module sfs_checker (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // FIFO strobes and flags
  input wire tx_push,
  input wire tx_pop,
  input wire rx_push,
  input wire rx_pop,
  input wire controller_enable,
  input wire tx_full_out,
  input wire rx_empty_out
);
  reg [5:0] tc_q;
  reg [5:0] rc_q;
  // Shadow levels; a push into a full FIFO or pop from empty is dropped
  always @(posedge aclk) begin
    if (!aresetn || !controller_enable) begin
      tc_q <= 6'h00;
      rc_q <= 6'h00;
    end else begin
      tc_q <= tc_q + 6'(tx_push && tc_q != 6'h20) - 6'(tx_pop && tc_q != 6'h00);
      rc_q <= rc_q + 6'(rx_push && rc_q != 6'h20) - 6'(rx_pop && rc_q != 6'h00);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Shadow trails a disabling write by one edge, so levels are compared while enabled
  a_tx_full_flag: assert property (controller_enable |-> tx_full_out == (tc_q == 6'h20))
    else $error("tx full flag wrong");
  a_rx_empty_flag: assert property (controller_enable |-> rx_empty_out == (rc_q == 6'h00))
    else $error("rx empty flag wrong");
  a_disable_clears: assert property (!controller_enable && !$past(controller_enable)
    |-> rx_empty_out && !tx_full_out) else $error("fifos not empty while disabled");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response held");
endmodule // sfs_checker

bind sfs_fifo_status sfs_checker sfs_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .tx_push, .tx_pop,
  .rx_push, .rx_pop, .controller_enable, .tx_full_out, .rx_empty_out);

// ### sim/sfs_engine_model.sv
// Shift engine stand-in: moves one word a cycle between the FIFOs.
// Assumes the bench pulses go for one cycle with a word count.
`timescale 1ns/1ps
module sfs_engine_model (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Command
  input  wire       go,
  input  wire [6:0] words,
  // Strobes to the block
  output wire       tx_pop,
  output wire       rx_push,
  output wire       engine_busy
);
  reg [6:0] left_q;
  // Faster than a real link, but the block only counts strobes
  always @(posedge aclk) begin
    if (!aresetn)
      left_q <= 7'h00;
    else if (go)
      left_q <= words;
    else if (left_q != 7'h00)
      left_q <= left_q - 7'h01;
  end
  assign tx_pop      = left_q != 7'h00;
  assign rx_push     = left_q != 7'h00;
  assign engine_busy = left_q != 7'h00;
endmodule // sfs_engine_model

// ### sim/tb.sv
// Self-checking bench for the FIFO status and interrupt block.
// Assumes checker and engine model are compiled before it.
`timescale 1ns/1ps
module tb;
  typedef struct {bit w; logic [7:0] a; logic [31:0] wd, ex; logic [1:0] rs;} sfs_row_t;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_push, rx_pop, go;
  reg  [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, d;
  reg  [3:0] s_axi_wstrb;
  reg  [6:0] words;
  reg  [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_pop, rx_push, engine_busy;
  wire controller_enable, tx_full_out, rx_empty_out, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int mismatches, samples_checked, i;
  sfs_row_t rows[16] = '{'{0,8'h24,0,32'h0c,0}, '{0,8'h1c,0,0,0}, '{0,8'h20,0,0,0}, '{0,8'h2c,0,0,0},
    '{0,8'h28,0,0,0}, '{0,8'h18,0,0,0}, '{0,8'h14,0,0,0}, '{0,8'h34,0,32'h01,0}, '{0,8'h30,0,0,0},
    '{0,8'h40,0,0,2}, '{1,8'h40,32'h05,0,2}, '{1,8'h1c,32'hff,0,0}, '{1,8'h24,32'hff,32'h0c,0},
    '{1,8'h14,32'hffffffff,32'h1f,0}, '{1,8'h18,32'hffffffff,32'h1f,0}, '{1,8'h28,32'hffffffff,32'h01,0}};
  sfs_fifo_status sfs_fifo_status_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_push, .tx_pop, .rx_push, .rx_pop, .engine_busy, .controller_enable, .tx_full_out, .rx_empty_out, .irq);
  sfs_engine_model sfs_engine_model_inst (.aclk, .aresetn, .go, .words, .tx_pop, .rx_push, .engine_busy);
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkp(input string n, input logic e, g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input [7:0] a, input [31:0] v, output [1:0] rs);
    bit pa, pw, ta, tw, bv;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      bv = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      pa = pa && !ta;
      pw = pw && !tw;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      if (bv) break;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] v, output [1:0] rs);
    bit pa, rv;
    pa = 1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      pa = pa && !s_axi_arready;
      rv = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      s_axi_arvalid <= pa;
      if (rv) break;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input [7:0] a, input [31:0] e);
    rd(a, d, r);
    chk("rdata", e, d);
    chk("rresp", 32'h0, r);
  endtask
  task automatic run(input [6:0] n);
    @(posedge aclk) go <= 1'b1;
    words <= n;
    @(posedge aclk) go <= 1'b0;
    repeat (n + 1) @(posedge aclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_push, rx_pop, go} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, words} = 0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 16; i++) begin
      if (rows[i].w) wr(rows[i].a, rows[i].wd, r);
      if (rows[i].w) chk("bresp", rows[i].rs, r);
      rd(rows[i].a, d, r);
      chk("rdata", rows[i].ex, d);
      chk("rresp", rows[i].rs, r);
    end
    repeat (3) @(negedge aclk);
    chkp("irq", 1, irq);
    wr(8'h28, 32'h0, r);
    wr(8'h08, 32'h1, r);
    chkp("controller_enable", 1, controller_enable);
    wr(8'h2c, 32'h1, r);
    repeat (3) @(negedge aclk);
    chkp("irq", 1, irq);
    rc(8'h30, 32'h01);
    repeat (33) @(posedge aclk) tx_push <= 1'b1;
    @(posedge aclk) tx_push <= 1'b0;
    repeat (3) @(negedge aclk);
    chkp("tx_full_out", 1, tx_full_out);
    chkp("irq", 0, irq);
    rc(8'h1c, 32'h20);
    rc(8'h24, 32'h0a);
    rc(8'h34, 32'h02);
    rc(8'h34, 32'h00);
    wr(8'h18, 32'h3, r);
    run(3);
    rc(8'h34, 32'h01);
    run(1);
    rc(8'h34, 32'h11);
    rc(8'h20, 32'h04);
    rc(8'h1c, 32'h1c);
    @(posedge aclk) go <= 1'b1;
    words <= 7'h14;
    @(posedge aclk) go <= 1'b0;
    rd(8'h24, d, r);
    chkp("busy", 1, d[0]);
    repeat (25) @(posedge aclk);
    rc(8'h24, 32'h00);
    repeat (25) @(posedge aclk) rx_pop <= 1'b1;
    @(posedge aclk) rx_pop <= 1'b0;
    repeat (3) @(negedge aclk);
    chkp("rx_empty_out", 1, rx_empty_out);
    rc(8'h34, 32'h05);
    run(33);
    rc(8'h24, 32'h14);
    wr(8'h2c, 32'h08, r);
    repeat (3) @(negedge aclk);
    chkp("irq", 1, irq);
    rc(8'h30, 32'h08);
    wr(8'h38, 32'h04, r);
    repeat (3) @(negedge aclk);
    chkp("irq", 0, irq);
    wr(8'h08, 32'h0, r);
    chkp("controller_enable", 0, controller_enable);
    rc(8'h20, 32'h00);
    rc(8'h24, 32'h0c);
    wr(8'h08, 32'h1, r);
    chkp("controller_enable", 1, controller_enable);
    @(posedge aclk) rx_pop <= 1'b1;
    @(posedge aclk) rx_pop <= 1'b0;
    wr(8'h38, 32'h02, r);
    rc(8'h34, 32'h01);
    @(posedge aclk) rx_pop <= 1'b1;
    @(posedge aclk) rx_pop <= 1'b0;
    wr(8'h38, 32'h01, r);
    rc(8'h34, 32'h01);
    repeat (33) @(posedge aclk) tx_push <= 1'b1;
    @(posedge aclk) tx_push <= 1'b0;
    wr(8'h38, 32'h08, r);
    rc(8'h34, 32'h00);
    repeat (2) @(posedge aclk) tx_push <= 1'b1;
    @(posedge aclk) tx_push <= 1'b0;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h1c, 32'h00);
    rc(8'h2c, 32'h00);
    rc(8'h34, 32'h01);
    stop_test;
  end
endmodule // tb
